//--- hw/phy_service.sv
// Transmitter control, status reporting and receive retiming of the serial link
`timescale 1ns/1ns

// How it works
// - Enable moves not-enabled to transition; transition stays; failure ignores it.
// - Disable returns any state except failure to not-enabled.
// - With zero transition cycles, enable goes straight to enabled.
// - Status reads active exactly while the transmitter is enabled.
// - Status reads fault when monitoring finds a fault; never without monitoring.
// - Status reads inactive in every other state, transition included.
// - Media follows each transmit bit only while status is active.
// - Transmit one drives the media high, zero drives it low.
// - Received bit is valid whenever the recovered clock strobe is issued.
// - Media high is delivered as one, media low as zero.
// - With no media input, received bit and strobe timing are undefined.
// - After reset the transmitter is in the not-enabled state.
// - A detected internal failure enters the failure state.
module phy_service
    import phy_pkg::*;
#(
    parameter logic [phy_pkg::CNT_W-1:0] TRANS_CYC = 16'(phy_pkg::TRANS_CYCLES),
    parameter logic [phy_pkg::CNT_W-1:0] REF_TIMEOUT = 16'(phy_pkg::REF_TIMEOUT_CYCLES),
    parameter bit FAULT_MONITOR = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Transmit control and data from the encoding layer
    input wire phy_pkg::tx_ctrl_s tx_ctrl,
    input wire logic tx_bit,
    // Transmit status and media drive
    output phy_pkg::tx_status_e tx_status,
    output logic media_out,
    // Transmitter self-monitor pin
    input wire logic fault_pin,
    // Receive media and its line clock pins
    input wire logic media_in,
    input wire logic line_clk,
    // Retimed receive data to the encoding layer
    output phy_pkg::rx_ind_s rx_ind,
    // Word reference from the encoding layer and lock report
    input wire logic word_ref,
    output logic ref_lock
);
    import phy_pkg::*;

    tx_state_e state_reg;
    tx_state_e state_next;
    logic [CNT_W-1:0] trans_cnt_reg;
    logic [CNT_W-1:0] ref_cnt_reg;
    tx_status_e status_reg;
    logic media_reg;
    rx_ind_s rx_reg;
    logic ref_lock_reg;
    logic fault_s;
    logic rx_data_s;
    logic line_rise;
    logic fault_hit;
    logic trans_done;
    logic line_unused;
    logic rx_rise_unused;

    // Fault pin and receive pins come from outside the clock domain
    pin_sync #(.W(1)) u_fault_sync (
        .clk(clk),
        .nrst(nrst),
        .pin(fault_pin),
        .level(fault_s),
        .rise()
    );

    // Data and clock share one synchroniser so they keep their alignment
    pin_sync #(.W(2)) u_rx_sync (
        .clk(clk),
        .nrst(nrst),
        .pin({media_in, line_clk}),
        .level({rx_data_s, line_unused}),
        .rise({rx_rise_unused, line_rise})
    );

    // Without a self-monitor the fault state is never entered
    assign fault_hit = FAULT_MONITOR && fault_s;

    assign trans_done = (trans_cnt_reg == TRANS_CYC - 16'h0001);

    // Next transmitter state; fault outranks disable, disable outranks enable
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            TX_OFF: begin
                if (fault_hit) begin
                    state_next = TX_FAIL;
                end else if (tx_ctrl.disable_req) begin
                    state_next = TX_OFF;
                end else if (tx_ctrl.enable_req) begin
                    if (TRANS_CYC == CNT_RESET) begin
                        state_next = TX_ON;
                    end else begin
                        state_next = TX_TRANS;
                    end
                end
            end
            TX_TRANS: begin
                if (fault_hit) begin
                    state_next = TX_FAIL;
                end else if (tx_ctrl.disable_req) begin
                    state_next = TX_OFF;
                end else if (trans_done) begin
                    state_next = TX_ON;
                end
            end
            TX_ON: begin
                if (fault_hit) begin
                    state_next = TX_FAIL;
                end else if (tx_ctrl.disable_req) begin
                    state_next = TX_OFF;
                end
            end
            TX_FAIL: begin
                // Only reset leaves failure; requests are ignored here
                state_next = TX_FAIL;
            end
            default: begin
                state_next = TX_OFF;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= TX_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // Transition timer restarts on every entry
    always_ff @(posedge clk) begin
        if (!nrst) begin
            trans_cnt_reg <= CNT_RESET;
        end else if (state_reg == TX_TRANS && state_next == TX_TRANS) begin
            trans_cnt_reg <= trans_cnt_reg + 16'h0001;
        end else begin
            trans_cnt_reg <= CNT_RESET;
        end
    end

    // Status follows the state it will hold, so both change on the same edge
    always_ff @(posedge clk) begin
        if (!nrst) begin
            status_reg <= STAT_INACTIVE;
        end else if (state_next == TX_ON) begin
            status_reg <= STAT_ACTIVE;
        end else if (state_next == TX_FAIL) begin
            status_reg <= STAT_FAULT;
        end else begin
            status_reg <= STAT_INACTIVE;
        end
    end

    // Media is held dark unless enabled; undriven bits after disable are harmless
    always_ff @(posedge clk) begin
        if (!nrst) begin
            media_reg <= MEDIA_RESET;
        end else if (state_next == TX_ON) begin
            media_reg <= tx_bit;
        end else begin
            media_reg <= MEDIA_RESET;
        end
    end

    // Retime received bit on each rising edge of the line clock
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx_reg <= '0;
        end else begin
            rx_reg.strobe <= line_rise;
            if (line_rise) begin
                rx_reg.bit_val <= rx_data_s;
            end
        end
    end

    // Word reference watchdog; a silent media leaves data undefined anyway
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ref_cnt_reg <= CNT_RESET;
            ref_lock_reg <= 1'b0;
        end else if (word_ref) begin
            ref_cnt_reg <= CNT_RESET;
            ref_lock_reg <= 1'b1;
        end else if (ref_cnt_reg == REF_TIMEOUT) begin
            ref_lock_reg <= 1'b0;
        end else begin
            ref_cnt_reg <= ref_cnt_reg + 16'h0001;
        end
    end

    assign tx_status = status_reg;
    assign media_out = media_reg;
    assign rx_ind = rx_reg;
    assign ref_lock = ref_lock_reg;

    // Checks

    sequence s_enable_from_off;
        state_reg == TX_OFF && tx_ctrl.enable_req && !tx_ctrl.disable_req && !fault_hit;
    endsequence

    sequence s_enter_next;
        (TRANS_CYC == CNT_RESET) ? state_reg == TX_ON : state_reg == TX_TRANS;
    endsequence

    a_enable_from_off: assert property (@(posedge clk) disable iff (!nrst)
        s_enable_from_off |=> s_enter_next)
        else $error("enable from off did not enter transition");

    a_trans_holds: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == TX_TRANS && !tx_ctrl.disable_req && !fault_hit && !trans_done
        |=> state_reg == TX_TRANS)
        else $error("transition left early");

    a_disable_to_off: assert property (@(posedge clk) disable iff (!nrst)
        state_reg != TX_FAIL && tx_ctrl.disable_req && !fault_hit |=> state_reg == TX_OFF)
        else $error("disable did not reach not-enabled");

    a_fail_sticky: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == TX_FAIL |=> state_reg == TX_FAIL && status_reg == STAT_FAULT)
        else $error("failure state was left");

    a_status_active: assert property (@(posedge clk) disable iff (!nrst)
        (status_reg == STAT_ACTIVE) == (state_reg == TX_ON))
        else $error("active status does not match enabled state");

    a_status_inactive: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == TX_OFF || state_reg == TX_TRANS) |-> status_reg == STAT_INACTIVE)
        else $error("inactive status missing");

    a_fault_entry: assert property (@(posedge clk) disable iff (!nrst)
        fault_hit |=> state_reg == TX_FAIL ##1 status_reg == STAT_FAULT)
        else $error("fault did not enter failure");

    a_media_follow: assert property (@(posedge clk) disable iff (!nrst)
        status_reg == STAT_ACTIVE |-> media_reg == $past(tx_bit))
        else $error("media does not follow transmit bit");

    a_media_dark: assert property (@(posedge clk) disable iff (!nrst)
        status_reg != STAT_ACTIVE |-> media_reg == MEDIA_RESET)
        else $error("media driven while not active");

    a_trans_bound: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == TX_TRANS |-> trans_cnt_reg < TRANS_CYC)
        else $error("transition overran its count");

    a_trans_done: assert property (@(posedge clk) disable iff (!nrst)
        state_reg == TX_TRANS && trans_done && !tx_ctrl.disable_req && !fault_hit
        |=> state_reg == TX_ON)
        else $error("transition did not complete");

    a_rx_capture: assert property (@(posedge clk) disable iff (!nrst)
        line_rise |=> rx_reg.strobe && rx_reg.bit_val == $past(rx_data_s))
        else $error("received bit not captured on strobe");

    a_rx_hold: assert property (@(posedge clk) disable iff (!nrst)
        !line_rise |=> rx_reg.bit_val == $past(rx_reg.bit_val))
        else $error("received bit changed between strobes");
endmodule

//--- hw/pin_sync.sv
// Two-stage synchroniser for pins with a rising-edge detector
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Asynchronous pins
    input wire logic [W-1:0] pin,
    // Synchronised level and its rising edge
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] prev_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise = sync_reg & ~prev_reg;
endmodule

//--- inc/phy_pkg.sv
// Shared constants, states and carriers of the serial link service block
package phy_pkg;

    // Core clock
    localparam int CLK_PERIOD_NS = 10;

    // Least time spent in transition before the transmitter counts as enabled
    localparam int TRANS_TIME_NS = 1000;
    localparam int TRANS_CYCLES = (TRANS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Longest gap between word references before lock is dropped
    localparam int REF_TIMEOUT_NS = 2000;
    localparam int REF_TIMEOUT_CYCLES = REF_TIMEOUT_NS / CLK_PERIOD_NS;

    // Counter width for both timers
    localparam int CNT_W = 16;

    // Reset values
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic MEDIA_RESET = 1'h0;

    // Transmitter states
    typedef enum logic [3:0] {
        TX_OFF = 4'h1,
        TX_TRANS = 4'h2,
        TX_ON = 4'h4,
        TX_FAIL = 4'h8
    } tx_state_e;

    // Reported transmitter status
    typedef enum logic [1:0] {
        STAT_INACTIVE = 2'h0,
        STAT_ACTIVE = 2'h1,
        STAT_FAULT = 2'h2
    } tx_status_e;

    // Enable and disable requests from the encoding layer
    typedef struct packed {
        logic enable_req;
        logic disable_req;
    } tx_ctrl_s;

    // Retimed receive bit with its recovered clock indication
    typedef struct packed {
        logic bit_val;
        logic strobe;
    } rx_ind_s;

endpackage

//--- testbench/link_far_end.sv
// Behavioural model of the encoding layer and the far media feeding the service block
`timescale 1ns/1ns
module link_far_end (
    // Core clock and bench controls
    input wire logic clk,
    input wire logic run,
    input wire logic ref_on,
    // Line side toward the service block
    output logic line_clk,
    output logic media_in,
    output logic word_ref,
    output logic sent_bit
);
    logic [7:0] lfsr = 8'hA5;
    logic [3:0] ref_cnt = 4'h0;

    initial begin
        line_clk = 1'b0;
        media_in = 1'b0;
        word_ref = 1'b0;
        sent_bit = 1'b0;
    end

    // Line clock rises only inside frames, never truncates a high phase
    always begin
        #62;
        line_clk = run;
        #63;
        line_clk = 1'b0;
    end

    // Expected bit is whatever the line held at the rising edge
    always @(posedge line_clk) sent_bit <= media_in;

    always @(negedge line_clk) begin
        lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        media_in <= lfsr[0];
    end

    // Idle line toggles so a stale bit cannot pass for data
    always @(posedge clk) if (!run && !line_clk) media_in <= ~media_in;

    // Word reference every 16 cycles while enabled
    always @(posedge clk) begin
        ref_cnt <= ref_cnt + 4'h1;
        word_ref <= ref_on && ref_cnt == 4'h0;
    end
endmodule

//--- testbench/phy_service_tb_top.sv
// Self-checking bench of the serial link service block
`timescale 1ns/1ns
module phy_service_tb_top;
    import phy_pkg::*;
    localparam int TC = 4;
    localparam int RT = 20;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    tx_ctrl_s tx_ctrl = '0;
    logic tx_bit = 1'b0;
    logic tx_prev = 1'b0;
    logic fault_pin = 1'b0;
    logic run = 1'b0;
    logic ref_on = 1'b0;
    logic line_clk, media_in, word_ref, sent_bit, media_a, media_b, lock_a;
    tx_status_e st_a, st_b;
    rx_ind_s rx_a;
    logic [31:0] seed = 32'h0000003D;
    int fail_count = 0;
    int tests_run = 0;
    int strobes = 0;

    phy_service #(.TRANS_CYC(16'(TC)), .REF_TIMEOUT(16'(RT))) u_phy_service (.clk(clk), .nrst(nrst),
        .tx_ctrl(tx_ctrl), .tx_bit(tx_bit), .tx_status(st_a), .media_out(media_a), .fault_pin(fault_pin),
        .media_in(media_in), .line_clk(line_clk), .rx_ind(rx_a), .word_ref(word_ref), .ref_lock(lock_a));
    // Empty transition and no self-monitor
    phy_service #(.TRANS_CYC(16'h0000), .FAULT_MONITOR(1'b0)) u_phy_service_b (.clk(clk), .nrst(nrst),
        .tx_ctrl(tx_ctrl), .tx_bit(tx_bit), .tx_status(st_b), .media_out(media_b), .fault_pin(fault_pin),
        .media_in(media_in), .line_clk(line_clk), .rx_ind(), .word_ref(word_ref), .ref_lock());
    link_far_end u_link_far_end (.clk(clk), .run(run), .ref_on(ref_on), .line_clk(line_clk),
        .media_in(media_in), .word_ref(word_ref), .sent_bit(sent_bit));

    always #5 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input logic [3:0] seen, input logic [3:0] want);
        tests_run++;
        if (seen !== want) begin
            fail_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Request held one cycle; returns at the edge that takes it
    task automatic ctrl(input logic en, input logic dis);
        @(posedge clk) tx_ctrl <= {en, dis};
        @(posedge clk) tx_ctrl <= '0;
    endtask

    task automatic do_reset();
        @(posedge clk) nrst <= 1'b0;
        fault_pin <= 1'b0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        check(st_a, STAT_INACTIVE);
        check(media_a, 1'b0);
        check(rx_a, 2'h0);
        check(lock_a, 1'b0);
        $display("reset test done");
    endtask

    // Valid random bits every cycle, also across disable
    always @(posedge clk) begin
        seed <= xs(seed);
        tx_prev <= tx_bit;
        tx_bit <= seed[0];
    end

    always @(negedge clk) begin
        if (nrst) begin
            check(media_a, st_a === STAT_ACTIVE ? tx_prev : 1'b0);
            check(media_b, st_b === STAT_ACTIVE ? tx_prev : 1'b0);
            if (rx_a.strobe === 1'b1) begin
                strobes++;
                check(rx_a.bit_val, sent_bit);
            end
        end
    end

    initial begin
        #100000;
        fail_count++;
        end_sim();
    end

    initial begin
        do_reset();
        run <= 1'b1;
        ref_on <= 1'b1;
        // Enable held high through the whole transition
        @(posedge clk) tx_ctrl <= {1'b1, 1'b0};
        @(posedge clk);
        for (int i = 0; i < TC; i++) begin
            @(negedge clk);
            check(st_a, STAT_INACTIVE);
            if (i == 1) check(st_b, STAT_ACTIVE);
            @(posedge clk);
        end
        tx_ctrl <= '0;
        @(negedge clk);
        check(st_a, STAT_ACTIVE);
        repeat (20 + seed[4:0]) @(posedge clk);
        ctrl(1'b0, 1'b1);
        @(negedge clk);
        check(st_a, STAT_INACTIVE);
        check(st_b, STAT_INACTIVE);
        $display("enable test done");
        // Disable back to back with enable cuts the transition short
        ctrl(1'b1, 1'b0);
        ctrl(1'b0, 1'b1);
        repeat (TC + 3) begin
            @(negedge clk);
            check(st_a, STAT_INACTIVE);
        end
        // Both requests at once: disable outranks enable
        ctrl(1'b1, 1'b1);
        @(negedge clk);
        check(st_a, STAT_INACTIVE);
        check(st_b, STAT_INACTIVE);
        $display("abort test done");
        ctrl(1'b1, 1'b0);
        repeat (TC + 2) @(posedge clk);
        @(posedge clk) fault_pin <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(st_a, STAT_ACTIVE);
        @(negedge clk);
        check(st_a, STAT_FAULT);
        check(st_b, STAT_ACTIVE);
        ctrl(1'b0, 1'b1);
        ctrl(1'b1, 1'b0);
        @(posedge clk) fault_pin <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check(st_a, STAT_FAULT);
        $display("fault test done");
        // Repair means a fresh reset, taken here in mid-run
        do_reset();
        repeat (40) @(posedge clk);
        @(negedge clk);
        check(lock_a, 1'b1);
        run <= 1'b0;
        ref_on <= 1'b0;
        repeat (RT + 20) @(posedge clk);
        @(negedge clk);
        check(lock_a, 1'b0);
        run <= 1'b1;
        ref_on <= 1'b1;
        repeat (300) @(posedge clk);
        check(strobes > 0, 1'b1);
        $display("receive test done");
        end_sim();
    end
endmodule
